// ---- sofmt_pkg.sv ----
// Operation
// R1 - global enable, resets disabled, gates all formatting
// R2 - format only if enabled, assigned, cells valid
// R3 - assign selects symbol position one to ten
// R4 - per-position assign status, default disabled passthrough
// R5 - positions beyond ten pass through unformatted
// R6 - cells one to hundred, ascending, extract/insert
// R7 - output only symbol bytes or literals; the code also ends each formatted string with a nul end marker
// R8 - extract copies from start; start zero disables
// R9 - extract copies length consecutive characters
// R10 - extract length zero ends cell array
// R11 - start and length bounded by symbol size
// R12 - insert length zero to four; zero ends
// R13 - longer literals split over consecutive cells
// R14 - hex pairs become single output bytes
// R15 - insert literal defaults to nul byte
// R16 - extract past end copies existing, continues
`default_nettype none
package sofmt_pkg;
   // ==========================================
   // sizes
   localparam int CELLS      = 100;
   localparam int POSITIONS  = 10;
   localparam int SYM_MAX    = 64;
   localparam int INS_MAX    = 4;
   localparam int FIFO_DEPTH = 32;
   // ==========================================
   // widths and constants
   localparam int CELL_W = 7;
   localparam int POS_W  = 4;
   localparam int LEN_W  = 7;
   localparam logic [7:0]        NUL_BYTE   = 8'h00;
   localparam logic [CELL_W-1:0] CELL_FIRST = 7'h01;
   localparam logic [CELL_W-1:0] CELL_LAST  = 7'h64;
   localparam logic [POS_W-1:0]  POS_FIRST  = 4'h1;
   localparam logic [POS_W-1:0]  POS_LAST   = 4'hA;
   localparam logic [LEN_W-1:0]  LEN_ZERO   = 7'h00;
   localparam logic [LEN_W-1:0]  LEN_ONE    = 7'h01;
   localparam logic [2:0]        INS_ZERO   = 3'h0;
   localparam logic [2:0]        INS_LIMIT  = 3'h4;
   localparam logic [1:0]        BYTE_ONE   = 2'h1;
   // ==========================================
   // formatter states, gray along capture, walk, emit
   typedef enum logic [2:0] {
      SOFMT_IDLE    = 3'b000,
      SOFMT_CAPTURE = 3'b001,
      SOFMT_CELL    = 3'b011,
      SOFMT_EMIT    = 3'b010,
      SOFMT_PASS    = 3'b110,
      SOFMT_FLUSH   = 3'b111
   } sofmt_state_t;
endpackage : sofmt_pkg
`default_nettype wire

// ---- sofmt_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sofmt_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;
   // ==========================================
   // handshakes; full and empty come from the count
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // full compare at count width, a pointer-width cast of the depth would wrap to zero
   assign in_ready  = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data  = mem[rd_ptr_reg];
   // storage has no reset, pointers guard it
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end
   // pointers and occupancy
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sofmt_fifo
`default_nettype wire

// ---- sofmt_formatter.sv ----
`timescale 1ns/1ps
`default_nettype none
module sofmt_formatter (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // global enable command
   input  wire logic        global_format_enable_command,
   input  wire logic        global_enable_value,
   // position assign command
   input  wire logic        position_assign_command,
   input  wire logic [3:0]  assign_position,
   input  wire logic        assign_status,
   // extract cell command
   input  wire logic        extract_cell_command,
   input  wire logic [6:0]  extract_index,
   input  wire logic [6:0]  extract_start,
   input  wire logic [6:0]  extract_length,
   // insert cell command, bytes already paired from hex
   input  wire logic        insert_cell_command,
   input  wire logic [6:0]  insert_index,
   input  wire logic [2:0]  insert_length,
   input  wire logic [31:0] insert_bytes,
   // decoder symbol stream
   input  wire logic        sym_valid,
   input  wire logic [7:0]  sym_data,
   input  wire logic        sym_last,
   input  wire logic [3:0]  sym_position,
   output logic             sym_ready,
   // serial output stream
   output logic             out_valid,
   output logic [7:0]       out_data,
   output logic             out_last,
   input  wire logic        out_ready,
   // status
   output logic             format_enabled,
   output logic             busy
);
   // ==========================================
   // configuration storage
   logic                    enable_reg;
   logic [sofmt_pkg::POSITIONS:1] assign_reg;
   logic                    cell_ins_reg [sofmt_pkg::CELLS];
   logic [6:0]              cell_start_reg [sofmt_pkg::CELLS];
   logic [6:0]              cell_len_reg [sofmt_pkg::CELLS];
   logic [31:0]             cell_lit_reg [sofmt_pkg::CELLS];
   logic [7:0]              sym_buf [sofmt_pkg::SYM_MAX];
   // ==========================================
   // engine state
   sofmt_pkg::sofmt_state_t state_reg;
   logic [6:0]              sym_cnt_reg;
   logic [6:0]              cell_reg;
   logic [6:0]              rd_reg;
   logic [6:0]              rem_reg;
   logic [1:0]              lit_reg;
   logic                    fmt_reg;
   logic                    f_valid;
   logic [8:0]              f_data;
   logic                    f_ready;
   logic [6:0]              ci;
   logic [8:0]              q_data;
   logic                    q_valid;
   assign ci = cell_reg - sofmt_pkg::CELL_FIRST;

   // global enable, comes up disabled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_reg <= 1'b0; // R1
      end else if (global_format_enable_command) begin
         enable_reg <= global_enable_value; // R1
      end
   end

   // one assign flag per position, out of range ignored
   generate
      for (genvar p = 1; p <= sofmt_pkg::POSITIONS; p++) begin : g_assign
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               assign_reg[p] <= 1'b0; // R4
            end else if (position_assign_command && assign_position == 4'(p)) begin
               assign_reg[p] <= assign_status; // R3
            end
         end
      end
   endgenerate

   // cell table; insert and extract share an index, last accepted command wins, extract wins when both come in one cycle
   generate
      for (genvar c = 0; c < sofmt_pkg::CELLS; c++) begin : g_cell
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cell_ins_reg[c]   <= 1'b0;
               cell_start_reg[c] <= sofmt_pkg::LEN_ZERO; // R8
               cell_len_reg[c]   <= sofmt_pkg::LEN_ZERO; // R10
               cell_lit_reg[c]   <= {4{sofmt_pkg::NUL_BYTE}}; // R15
            end else if (extract_cell_command && extract_index == 7'(c + 1)) begin
               cell_ins_reg[c]   <= 1'b0; // R6
               cell_start_reg[c] <= extract_start;
               cell_len_reg[c]   <= extract_length;
            end else if (insert_cell_command && insert_index == 7'(c + 1)
                         && insert_length <= sofmt_pkg::INS_LIMIT) begin
               cell_ins_reg[c]   <= 1'b1; // R12
               cell_len_reg[c]   <= {4'h0, insert_length};
               cell_lit_reg[c]   <= insert_bytes; // R14
            end
         end
      end
   endgenerate

   // symbol capture buffer, bytes beyond capacity dropped
   always_ff @(posedge clk) begin
      if (state_reg == sofmt_pkg::SOFMT_CAPTURE && sym_valid && sym_cnt_reg < 7'(sofmt_pkg::SYM_MAX)) begin
         sym_buf[sym_cnt_reg[5:0]] <= sym_data;
      end
   end

   // main sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg   <= sofmt_pkg::SOFMT_IDLE;
         sym_cnt_reg <= sofmt_pkg::LEN_ZERO;
         cell_reg    <= sofmt_pkg::CELL_FIRST;
         rd_reg      <= sofmt_pkg::LEN_ZERO;
         rem_reg     <= sofmt_pkg::LEN_ZERO;
         lit_reg     <= 2'h0;
         fmt_reg     <= 1'b0;
      end else begin
         case (state_reg)
            sofmt_pkg::SOFMT_IDLE: begin
               sym_cnt_reg <= sofmt_pkg::LEN_ZERO;
               if (sym_valid) begin
                  // positions past ten never match an assign flag
                  fmt_reg   <= enable_reg && sym_position >= sofmt_pkg::POS_FIRST
                               && sym_position <= sofmt_pkg::POS_LAST
                               && assign_reg[sym_position]; // R2 R5
                  state_reg <= sofmt_pkg::SOFMT_CAPTURE;
               end
            end
            sofmt_pkg::SOFMT_CAPTURE: begin
               if (sym_valid) begin
                  if (sym_cnt_reg < 7'(sofmt_pkg::SYM_MAX)) sym_cnt_reg <= sym_cnt_reg + sofmt_pkg::LEN_ONE;
                  if (sym_last) begin
                     cell_reg <= sofmt_pkg::CELL_FIRST; // R6
                     rd_reg   <= sofmt_pkg::LEN_ZERO;
                     // no valid first cell means plain output
                     state_reg <= (fmt_reg && cell_len_reg[0] != sofmt_pkg::LEN_ZERO)
                                  ? sofmt_pkg::SOFMT_CELL : sofmt_pkg::SOFMT_PASS; // R2
                  end
               end
            end
            sofmt_pkg::SOFMT_CELL: begin
               if (cell_len_reg[ci] == sofmt_pkg::LEN_ZERO || cell_reg > sofmt_pkg::CELL_LAST) begin
                  state_reg <= sofmt_pkg::SOFMT_FLUSH; // R10 R12
               end else if (cell_ins_reg[ci]) begin
                  lit_reg   <= 2'h0;
                  rem_reg   <= cell_len_reg[ci];
                  state_reg <= sofmt_pkg::SOFMT_EMIT;
               end else if (cell_start_reg[ci] == sofmt_pkg::LEN_ZERO
                            || cell_start_reg[ci] > sym_cnt_reg) begin
                  cell_reg <= cell_reg + sofmt_pkg::LEN_ONE; // R8 R11
               end else begin
                  rd_reg  <= cell_start_reg[ci] - sofmt_pkg::LEN_ONE; // R8
                  // clip at end of data so nothing invented is sent
                  rem_reg <= (cell_len_reg[ci] > sym_cnt_reg - cell_start_reg[ci] + sofmt_pkg::LEN_ONE)
                             ? sym_cnt_reg - cell_start_reg[ci] + sofmt_pkg::LEN_ONE
                             : cell_len_reg[ci]; // R9 R16
                  state_reg <= sofmt_pkg::SOFMT_EMIT;
               end
            end
            sofmt_pkg::SOFMT_EMIT: begin
               if (f_ready) begin
                  rem_reg <= rem_reg - sofmt_pkg::LEN_ONE;
                  if (cell_ins_reg[ci]) lit_reg <= lit_reg + sofmt_pkg::BYTE_ONE; // R13
                  else rd_reg <= rd_reg + sofmt_pkg::LEN_ONE;
                  if (rem_reg == sofmt_pkg::LEN_ONE) begin
                     cell_reg  <= cell_reg + sofmt_pkg::LEN_ONE; // R6
                     state_reg <= sofmt_pkg::SOFMT_CELL;
                  end
               end
            end
            sofmt_pkg::SOFMT_PASS: begin
               if (f_ready) begin
                  rd_reg <= rd_reg + sofmt_pkg::LEN_ONE; // R4
                  if (rd_reg + sofmt_pkg::LEN_ONE >= sym_cnt_reg) state_reg <= sofmt_pkg::SOFMT_IDLE;
               end
            end
            sofmt_pkg::SOFMT_FLUSH: begin
               if (f_ready) state_reg <= sofmt_pkg::SOFMT_IDLE;
            end
            default: state_reg <= sofmt_pkg::SOFMT_IDLE;
         endcase
      end
   end

   // byte source mux: literal first byte in low lane, else symbol copy
   always_comb begin
      f_valid = 1'b0;
      f_data  = 9'h000;
      case (state_reg)
         sofmt_pkg::SOFMT_EMIT: begin
            f_valid = 1'b1;
            f_data  = cell_ins_reg[ci] ? {1'b0, cell_lit_reg[ci][8*lit_reg +: 8]}
                                       : {1'b0, sym_buf[rd_reg[5:0]]}; // R7
         end
         sofmt_pkg::SOFMT_PASS: begin
            f_valid = 1'b1;
            f_data  = {rd_reg + sofmt_pkg::LEN_ONE >= sym_cnt_reg, sym_buf[rd_reg[5:0]]};
         end
         sofmt_pkg::SOFMT_FLUSH: begin
            f_valid = 1'b1;
            f_data  = 9'h100; // nul end marker closes the string
         end
         default: begin
            f_valid = 1'b0;
            f_data  = 9'h000;
         end
      endcase
   end

   // output queue, the serial side back-pressures the engine
   sofmt_fifo #(.WIDTH(9), .DEPTH(sofmt_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (f_valid),
      .in_data   (f_data),
      .in_ready  (f_ready),
      .out_valid (q_valid),
      .out_data  (q_data),
      .out_ready (!out_valid || out_ready)
   );

   // registered outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_valid      <= 1'b0;
         out_data       <= sofmt_pkg::NUL_BYTE;
         out_last       <= 1'b0;
         format_enabled <= 1'b0;
         busy           <= 1'b0;
         sym_ready      <= 1'b0;
      end else begin
         if (!out_valid || out_ready) begin
            out_valid <= q_valid;
            out_data  <= q_data[7:0];
            out_last  <= q_data[8];
         end
         format_enabled <= enable_reg;
         busy           <= state_reg != sofmt_pkg::SOFMT_IDLE;
         sym_ready      <= state_reg == sofmt_pkg::SOFMT_IDLE;
      end
   end

   // ==========================================
   // checks
   a_disabled_passes: assert property (@(posedge clk) disable iff (!arst_n)
      !enable_reg |-> state_reg != sofmt_pkg::SOFMT_CELL) // R1
      else $error("formatting while globally disabled");
   a_len_zero_ends: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == sofmt_pkg::SOFMT_CELL && cell_reg <= sofmt_pkg::CELL_LAST
      && cell_len_reg[ci] == sofmt_pkg::LEN_ZERO |=> state_reg == sofmt_pkg::SOFMT_FLUSH) // R10
      else $error("zero length cell did not end string");
   a_insert_bound: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == sofmt_pkg::SOFMT_EMIT && cell_ins_reg[ci] |-> rem_reg <= 7'(sofmt_pkg::INS_MAX)) // R12
      else $error("insert longer than four bytes");
   a_extract_clip: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == sofmt_pkg::SOFMT_EMIT && !cell_ins_reg[ci] |-> rd_reg < sym_cnt_reg) // R16
      else $error("extract read past symbol end");

   // ==========================================
   // multi-step checks, three built from named sequences
   // symbol closed while not marked for formatting
   sequence s_plain_end;
      state_reg == sofmt_pkg::SOFMT_CAPTURE && sym_valid && sym_last && !fmt_reg;
   endsequence
   // end marker accepted by the queue
   sequence s_flush_taken;
      state_reg == sofmt_pkg::SOFMT_FLUSH && f_ready;
   endsequence
   // host refused the word on the output register
   sequence s_word_refused;
      out_valid && !out_ready;
   endsequence

   a_plain_passes: assert property (@(posedge clk) disable iff (!arst_n)
      s_plain_end |=> state_reg == sofmt_pkg::SOFMT_PASS) // R4
      else $error("unassigned symbol entered formatting");
   a_beyond_range: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == sofmt_pkg::SOFMT_IDLE && sym_valid && sym_position > sofmt_pkg::POS_LAST
      |=> !fmt_reg) // R5
      else $error("position past range marked for formatting");
   a_flush_closes: assert property (@(posedge clk) disable iff (!arst_n)
      s_flush_taken |=> state_reg == sofmt_pkg::SOFMT_IDLE) // R10
      else $error("end marker queued but string not closed");
   // a refused word must not be swapped, or the host would lose a byte
   a_output_held: assert property (@(posedge clk) disable iff (!arst_n)
      s_word_refused |=> out_valid && $stable(out_data) && $stable(out_last)) // R7
      else $error("refused output word changed");
   a_enable_copy: assert property (@(posedge clk) disable iff (!arst_n)
      format_enabled == $past(enable_reg)) // R1
      else $error("enable status does not follow setting");
endmodule : sofmt_formatter
`default_nettype wire

// ---- sofmt_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sofmt_host_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // stream from the formatter
   input  wire logic       out_valid,
   input  wire logic [7:0] out_data,
   input  wire logic       out_last,
   output logic            out_ready,
   // bench control
   input  wire logic       stall_en
);
   logic [8:0] got[$];
   int         hold_breaks;
   logic [8:0] held;
   logic       pend;
   // ==========================================
   // host sink: random back-pressure, a stalled host takes nothing
   initial begin
      out_ready   = 1'b0;
      hold_breaks = 0;
      pend        = 1'b0;
      held        = 9'h000;
      forever begin
         @(posedge clk);
         if (arst_n && out_valid && out_ready) got.push_back({out_last, out_data});
         // a refused word must stand unchanged until taken
         if (pend && {out_valid, out_last, out_data} !== {1'b1, held}) hold_breaks++;
         pend = arst_n && out_valid && !out_ready;
         held = {out_last, out_data};
         #1 out_ready = !stall_en && ($urandom % 4 != 0);
      end
   end
endmodule : sofmt_host_model
`default_nettype wire

// ---- symbol_output_formatter_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module symbol_output_formatter_tb_top;
   logic        clk, arst_n, stall_en;
   logic        en_cmd, en_val, asg_cmd, asg_st, ext_cmd, ins_cmd;
   logic [3:0]  asg_pos, sym_pos;
   logic [6:0]  ext_idx, ext_st, ext_len, ins_idx;
   logic [2:0]  ins_len;
   logic [31:0] ins_bytes;
   logic        sym_valid, sym_last, sym_ready, out_valid, out_last, out_ready, fmt_en, busy;
   logic [7:0]  sym_data, out_data;
   int          errors, samples_checked, cycles;
   // ==========================================
   // bench model of the configuration
   bit          m_en;
   bit          m_asg[1:10];
   bit          m_ins[1:100];
   int          m_st[1:100];
   int          m_len[1:100];
   bit [31:0]   m_b[1:100];
   logic [7:0]  sq[$];
   logic [8:0]  exq[$];

   sofmt_formatter uut (
      .clk(clk), .arst_n(arst_n),
      .global_format_enable_command(en_cmd), .global_enable_value(en_val),
      .position_assign_command(asg_cmd), .assign_position(asg_pos), .assign_status(asg_st),
      .extract_cell_command(ext_cmd), .extract_index(ext_idx), .extract_start(ext_st),
      .extract_length(ext_len),
      .insert_cell_command(ins_cmd), .insert_index(ins_idx), .insert_length(ins_len),
      .insert_bytes(ins_bytes),
      .sym_valid(sym_valid), .sym_data(sym_data), .sym_last(sym_last), .sym_position(sym_pos),
      .sym_ready(sym_ready),
      .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
      .format_enabled(fmt_en), .busy(busy));

   sofmt_host_model host (
      .clk(clk), .arst_n(arst_n), .out_valid(out_valid), .out_data(out_data),
      .out_last(out_last), .out_ready(out_ready), .stall_en(stall_en));

   // ==========================================
   // clock and run limit, a hang counts as a mismatch
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   // ==========================================
   // command pulses, model updated as the device should
   task automatic p_ext(input int i, input int s, input int l);
      @(posedge clk); #1;
      {ext_cmd, ext_idx, ext_st, ext_len} = {1'b1, 7'(i), 7'(s), 7'(l)};
      @(posedge clk); #1;
      ext_cmd = 1'b0;
      {m_ins[i], m_st[i], m_len[i]} = {1'b0, s, l};
   endtask : p_ext

   task automatic p_ins(input int i, input int l, input bit [31:0] b);
      @(posedge clk); #1;
      {ins_cmd, ins_idx, ins_len, ins_bytes} = {1'b1, 7'(i), 3'(l), b};
      @(posedge clk); #1;
      ins_cmd = 1'b0;
      if (l <= 4) {m_ins[i], m_len[i], m_b[i]} = {1'b1, l, b};
   endtask : p_ins

   task automatic p_asg(input int p, input bit s);
      @(posedge clk); #1;
      {asg_cmd, asg_pos, asg_st} = {1'b1, 4'(p), s};
      @(posedge clk); #1;
      asg_cmd = 1'b0;
      if (p >= 1 && p <= 10) m_asg[p] = s;
   endtask : p_asg

   task automatic p_en(input bit v);
      @(posedge clk); #1;
      {en_cmd, en_val} = {1'b1, v};
      @(posedge clk); #1;
      en_cmd = 1'b0;
      m_en   = v;
      // status output is a registered copy, one edge behind the setting
      @(posedge clk); #1;
      check(fmt_en, v, "format enable");
   endtask : p_en

   // expected stream: formatted string plus closing nul, or the symbol unchanged
   function automatic void build(input int pos);
      int n;
      bit fmt;
      n   = sq.size();
      exq.delete();
      fmt = m_en && pos >= 1 && pos <= 10 && m_asg[pos] && m_len[1] != 0;
      for (int i = 1; fmt && i <= 100; i++) begin
         if (m_len[i] == 0) break;
         for (int k = 0; k < m_len[i]; k++)
            if (m_ins[i]) exq.push_back({1'b0, m_b[i][8*k +: 8]});
            else if (m_st[i] != 0 && m_st[i] + k <= n) exq.push_back({1'b0, sq[m_st[i]+k-1]});
      end
      if (fmt) exq.push_back(9'h100);
      else foreach (sq[j]) exq.push_back({j == n - 1, sq[j]});
   endfunction : build

   // one symbol: first byte held two cycles, then one byte a cycle
   task automatic send(input int pos, input int n);
      int t;
      sq.delete();
      for (int j = 0; j < n; j++) sq.push_back(8'h20 + 8'($urandom % 95));
      build(pos);
      host.got.delete();
      @(posedge clk); #1;
      {sym_valid, sym_pos, sym_data, sym_last} = {1'b1, 4'(pos), sq[0], n == 1};
      @(posedge clk); #1;
      for (int j = 1; j < n; j++) begin
         @(posedge clk); #1;
         {sym_data, sym_last} = {sq[j], j == n - 1};
      end
      @(posedge clk); #1;
      {sym_valid, sym_last} = 2'b00;
      t = 0;
      while ((busy !== 1'b0 || host.got.size() < exq.size()) && t < 3000) begin
         @(posedge clk);
         t++;
      end
      repeat (4) @(posedge clk);
      check(host.got.size(), exq.size(), "byte count");
      foreach (exq[j]) if (j < host.got.size()) check(host.got[j], exq[j], "output byte");
   endtask : send

   // long symbol while the host stalls, so the buffer fills up
   task automatic stalled(input int pos, input int n);
      #1 stall_en = 1'b1;
      fork
         send(pos, n);
         begin
            repeat (150) @(posedge clk);
            #1 stall_en = 1'b0;
         end
      join
   endtask : stalled

   // ==========================================
   // main sequence
   initial begin
      {en_cmd, en_val, asg_cmd, asg_st, ext_cmd, ins_cmd, asg_pos, sym_pos} = '0;
      {ext_idx, ext_st, ext_len, ins_idx, ins_len, ins_bytes} = '0;
      {sym_valid, sym_last, sym_data, arst_n, stall_en} = '0;
      void'($urandom(32'h244f));
      repeat (20) @(posedge clk);
      #1 arst_n = 1'b1;
      check(fmt_en, 1'b0, "enable after reset");
      check(busy, 1'b0, "busy after reset");
      p_asg(1, 1'b1);
      p_ins(1, 2, 32'h0000_6948);
      send(1, 2);
      p_en(1'b1);
      send(1, 2);
      send(2, 5);
      send(11, 6);
      // mixed cells, overlong extract, nul literal, terminator hides cell 8
      p_ext(1, 3, 2);
      p_ins(2, 4, 32'h5a59_5857);
      p_ins(3, 2, 32'h0000_2121);
      p_ext(4, 1, 1);
      p_ext(5, 5, 10);
      p_ins(6, 1, 32'h0000_0000);
      p_ext(7, 0, 0);
      p_ins(8, 3, 32'h0041_4243);
      send(1, 8);
      p_ins(3, 5, 32'hffff_ffff);
      send(1, 8);
      p_ins(3, 0, 32'h0000_0000);
      send(1, 8);
      for (int p = 1; p <= 10; p++) p_asg(p, 1'($urandom % 2));
      for (int p = 1; p <= 10; p++) send(p, 3 + $urandom % 6);
      p_ext(1, 0, 0);
      send(1, 4);
      p_ext(1, 1, 64);
      p_ins(2, 0, 32'h0000_0000);
      stalled(1, 64);
      p_en(1'b0);
      stalled(1, 64);
      check(host.hold_breaks, 0, "held output word");
      wrap_up();
   end
endmodule : symbol_output_formatter_tb_top
`default_nettype wire
